// ### inc/sbs_pkg.sv
package sbs_pkg;

    // =====================================================================
    // register map (axi4-lite, byte addresses)
    // =====================================================================
    localparam int SBS_AXI_AW = 4;
    localparam logic [3:0] SBS_OFF_MODE = 4'h0;
    localparam logic [3:0] SBS_OFF_STATUS = 4'h4;

    // mode register field positions
    localparam int SBS_MODE_ORDER = 0;     // seq_order_sel: 0 linear, 1 interleaved
    localparam int SBS_MODE_BYPASS_N = 1;  // bypass_output_reg_n: 0 flow-through
    localparam int SBS_MODE_DESEL = 2;     // deselect_latency_sel: 0 dual, 1 single
    localparam int SBS_MODE_DRIVE = 3;     // drive_strength_sel: 0 high drive
    localparam int SBS_MODE_PAR_N = 4;     // parity_lane_enable_n: 0 parity active
    localparam int SBS_MODE_SLEEP = 5;     // sleep_request: 1 standby
    localparam int SBS_MODE_W = 6;

    // reset value models the pull-ups and pull-downs on unconnected mode pins
    localparam logic [5:0] SBS_MODE_RST = 6'h0f;

    // status register field positions
    localparam int SBS_ST_LOW = 0;         // two bits: current burst word
    localparam int SBS_ST_BURST = 2;
    localparam int SBS_ST_SLEEP = 3;
    localparam int SBS_ST_DRIVE = 4;

    // axi response codes
    localparam logic [1:0] SBS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SBS_RESP_SLVERR = 2'h2;

    // =====================================================================
    // memory geometry
    // =====================================================================
    localparam int SBS_ADDR_W = 18;
    localparam int SBS_LANES = 4;
    localparam int SBS_LANE_W = 8;

    // burst state
    typedef enum logic {
        SBS_IDLE = 1'b0,
        SBS_BURST = 1'b1
    } sbs_state_t;

    // burst word address from start value and step count
    function automatic logic [1:0] sbs_burst_addr(input logic [1:0] start,
                                                  input logic [1:0] offset,
                                                  input logic interleave);
        if (interleave) begin
            return start ^ offset;
        end
        return 2'(start + offset);
    endfunction : sbs_burst_addr

endpackage : sbs_pkg

// ### rtl/sbs_burst_counter.sv
module sbs_burst_counter
    import sbs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic load,
    input wire logic [1:0] start,
    input wire logic step,
    input wire logic interleave,
    // burst word positions
    output logic [1:0] cur_low,
    output logic [1:0] next_low,
    output logic [1:0] start_low,
    output logic [1:0] offset
);

    logic [1:0] start_reg;
    logic [1:0] offset_reg;

    // =====================================================================
    // preset on load, advance on step; two bits wrap after four words
    // =====================================================================
    always_ff @(posedge clk) begin
        if (srst) begin
            start_reg <= 2'h0;
            offset_reg <= 2'h0;
        end else if (load) begin
            start_reg <= start;        // RL1
            offset_reg <= 2'h0;
        end else if (step) begin
            offset_reg <= 2'(offset_reg + 2'h1);  // RL7 RL10
        end
    end

    // linear adds, interleaved xors the step count into the start value
    assign cur_low = sbs_burst_addr(start_reg, offset_reg, interleave);  // RL9
    assign next_low = sbs_burst_addr(start_reg, 2'(offset_reg + 2'h1), interleave);
    assign start_low = start_reg;
    assign offset = offset_reg;

endmodule : sbs_burst_counter

// ### rtl/sbs_sram_core.sv
// Behaviour
// RL1: two low address bits give the start word and preset the burst counter.
// RL2: each active-low lane select enables writing of its own lane only.
// RL3: lane strobe low writes only lanes whose selects are low.
// RL4: all-lane write low writes every lane regardless of other selects.
// RL5: selected only with select-low low and select-high high; else deselect.
// RL6: data drivers enabled only while output enable is low.
// RL7: advance low steps the burst counter; high holds the current word.
// RL8: either address strobe low loads a new external address.
// RL9: linear order adds step count; interleaved order xors it with start.
// RL10: burst counter returns to its start value on the fifth clock.
// RL11: output register select low is flow-through, high is pipelined.
// RL12: sleep request high puts the device in standby; low is normal.
// RL13: deselect latency select low is dual-cycle, high is single-cycle.
// RL14: drive strength select low gives high drive, high gives low drive.
// RL15: parity enable low activates parity bits; high leaves eight-bit lanes.
// RL16: unconnected mode selects take their pulled defaults.
// RL17: every synchronous input and output uses the rising clock edge.
// RL18: a burst starts on an address load; advance then walks it.
// RL19: single-cycle deselect turns drivers off one stage before read data.
// RL20: dual-cycle deselect turns drivers off after the second clock edge.
// RL21: memory contents are kept during sleep.
// RL22: pipelined read data after next edge; flow-through in the same cycle.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
module sbs_sram_core
    import sbs_pkg::*;
#(
    parameter int ADDR_W = SBS_ADDR_W
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // axi4-lite write channels
    input wire logic [SBS_AXI_AW-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read channels
    input wire logic [SBS_AXI_AW-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // sram address and control
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic CHIP_SELECT_LOW_N,
    input wire logic CHIP_SELECT_HIGH,
    input wire logic CPU_ADDR_LOAD_N,
    input wire logic CTRL_ADDR_LOAD_N,
    input wire logic BURST_STEP_N,
    input wire logic ALL_LANE_WRITE_N,
    input wire logic LANE_WRITE_STROBE_N,
    input wire logic [3:0] LANE_WRITE_N,
    input wire logic OUTPUT_ENABLE_N,
    // sram data lanes
    input wire logic [31:0] DATA_IN,
    input wire logic [3:0] PARITY_IN,
    output logic [31:0] DATA_OUT,
    output logic [3:0] PARITY_OUT,
    output logic DATA_OE_N,
    output logic PARITY_OE_N,
    // mode status
    output logic DRIVE_HIGH,
    output logic SLEEP_ACTIVE
);

    localparam int WORD_W = SBS_LANES * (SBS_LANE_W + 1);

    logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [SBS_MODE_W-1:0] mode_reg;
    sbs_state_t state_reg;
    logic [ADDR_W-3:0] base_hi_reg;
    logic [WORD_W-1:0] rd1_reg, rd2_reg;
    logic rd1_valid_reg, rd2_valid_reg, desel1_reg;
    logic aw_hold_reg, w_hold_reg;
    logic [SBS_AXI_AW-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] cur_low, next_low, start_low, offset;
    logic selected, is_write, load, step, desel, go, wr_fire;
    logic [3:0] lanes;
    logic [ADDR_W-1:0] acc_addr;
    logic drive, interleave, pipelined, single_desel, sleep, parity_on;

    // =====================================================================
    // mode decode
    // =====================================================================
    assign interleave = mode_reg[SBS_MODE_ORDER];
    assign pipelined = mode_reg[SBS_MODE_BYPASS_N];       // RL11
    assign single_desel = mode_reg[SBS_MODE_DESEL];       // RL13
    assign sleep = mode_reg[SBS_MODE_SLEEP];              // RL12
    assign parity_on = !mode_reg[SBS_MODE_PAR_N];         // RL15
    assign DRIVE_HIGH = !mode_reg[SBS_MODE_DRIVE];        // RL14
    assign SLEEP_ACTIVE = sleep;

    // =====================================================================
    // command decode
    // =====================================================================
    assign selected = !CHIP_SELECT_LOW_N && CHIP_SELECT_HIGH;  // RL5
    assign is_write = !ALL_LANE_WRITE_N || !LANE_WRITE_STROBE_N;
    // all-lane write overrides, else strobe passes the lane selects
    assign lanes = !ALL_LANE_WRITE_N ? 4'hf :                       // RL4
                   (!LANE_WRITE_STROBE_N ? ~LANE_WRITE_N : 4'h0);  // RL2 RL3

    // priority: cpu load, then controller load, then burst continue
    always_comb begin
        load = 1'b0;
        step = 1'b0;
        desel = 1'b0;
        go = 1'b0;
        acc_addr = ADDR;
        if (sleep) begin
            go = 1'b0;                                     // RL12
        end else if (!CPU_ADDR_LOAD_N && !CHIP_SELECT_LOW_N) begin
            load = selected;                               // RL8 RL18
            go = selected;
            desel = !selected;                             // RL5
        end else if (!CTRL_ADDR_LOAD_N) begin
            load = selected;                               // RL8 RL18
            go = selected;
            desel = !selected;
        end else if (state_reg == SBS_BURST) begin
            go = 1'b1;
            step = !BURST_STEP_N;                          // RL7
            acc_addr = {base_hi_reg, step ? next_low : cur_low};
        end
    end

    // cpu strobe always reads on its first cycle
    logic acc_write;
    assign acc_write = go && is_write && !(!CPU_ADDR_LOAD_N && !CHIP_SELECT_LOW_N);

    sbs_burst_counter u_counter (
        .clk(REF_CLK),
        .srst(SRST),
        .load(load),
        .start(ADDR[1:0]),
        .step(step),
        .interleave(interleave),
        .cur_low(cur_low),
        .next_low(next_low),
        .start_low(start_low),
        .offset(offset)
    );

    // burst state and upper address held for the burst
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state_reg <= SBS_IDLE;
            base_hi_reg <= '0;
        end else if (load) begin
            state_reg <= SBS_BURST;                        // RL18 RL17
            base_hi_reg <= ADDR[ADDR_W-1:2];
        end else if (desel) begin
            state_reg <= SBS_IDLE;
        end
    end

    // =====================================================================
    // memory array: never cleared, so contents survive sleep
    // =====================================================================
    always_ff @(posedge REF_CLK) begin
        if (acc_write) begin                               // RL21
            for (int i = 0; i < SBS_LANES; i++) begin
                if (lanes[i]) begin
                    mem[acc_addr][i*SBS_LANE_W +: SBS_LANE_W] <= DATA_IN[i*SBS_LANE_W +: SBS_LANE_W];
                    if (parity_on) begin
                        mem[acc_addr][32+i] <= PARITY_IN[i];  // RL15
                    end
                end
            end
        end
    end

    // read pipeline: stage one feeds flow-through, stage two pipelined
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rd1_reg <= '0;
            rd2_reg <= '0;
            rd1_valid_reg <= 1'b0;
            rd2_valid_reg <= 1'b0;
            desel1_reg <= 1'b0;
        end else begin
            if (go && !acc_write) begin
                rd1_reg <= mem[acc_addr];
            end
            rd1_valid_reg <= go && !acc_write;             // RL22
            desel1_reg <= desel || sleep;
            rd2_reg <= rd1_reg;
            rd2_valid_reg <= rd1_valid_reg;
        end
    end

    // =====================================================================
    // output drivers
    // =====================================================================
    always_comb begin
        if (!pipelined) begin
            drive = rd1_valid_reg;                               // RL11 RL22
        end else begin
            drive = rd2_valid_reg && !(single_desel && desel1_reg);  // RL19 RL20
        end
        drive = drive && !OUTPUT_ENABLE_N && !sleep;             // RL6 RL12
    end

    assign DATA_OE_N = !drive;
    assign PARITY_OE_N = !(drive && parity_on);                  // RL15
    assign DATA_OUT = pipelined ? rd2_reg[31:0] : rd1_reg[31:0];
    assign PARITY_OUT = parity_on ? (pipelined ? rd2_reg[35:32] : rd1_reg[35:32]) : 4'h0;

    // =====================================================================
    // axi4-lite slave
    // =====================================================================
    assign AWREADY = !aw_hold_reg && !BVALID;
    assign WREADY = !w_hold_reg && !BVALID;
    assign ARREADY = !RVALID;
    assign wr_fire = aw_hold_reg && w_hold_reg && !BVALID;

    // address and data captured in either order
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= AWADDR;
            end else if (wr_fire) begin
                aw_hold_reg <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= WDATA;
                w_strb_reg <= WSTRB;
            end else if (wr_fire) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    // write response and mode register
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            BVALID <= 1'b0;
            BRESP <= SBS_RESP_OKAY;
            mode_reg <= SBS_MODE_RST;                      // RL16
        end else if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP <= (aw_addr_reg == SBS_OFF_MODE) ? SBS_RESP_OKAY : SBS_RESP_SLVERR;
            if (aw_addr_reg == SBS_OFF_MODE && w_strb_reg[0]) begin
                mode_reg <= w_data_reg[SBS_MODE_W-1:0];
            end
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // read data and response
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= SBS_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= SBS_RESP_OKAY;
            RDATA <= '0;
            case (ARADDR)
                SBS_OFF_MODE: begin
                    RDATA[SBS_MODE_W-1:0] <= mode_reg;
                end
                SBS_OFF_STATUS: begin
                    RDATA[SBS_ST_LOW +: 2] <= cur_low;
                    RDATA[SBS_ST_BURST] <= (state_reg == SBS_BURST);
                    RDATA[SBS_ST_SLEEP] <= sleep;
                    RDATA[SBS_ST_DRIVE] <= drive;
                end
                default: begin
                    RRESP <= SBS_RESP_SLVERR;
                end
            endcase
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    a_oe_gates_drive: assert property (OUTPUT_ENABLE_N |-> DATA_OE_N)  // RL6
        else $error("drivers on while output enable high");
    a_sleep_standby: assert property (sleep |-> DATA_OE_N && !go)  // RL12
        else $error("activity during sleep");
    a_global_lanes: assert property (acc_write && !ALL_LANE_WRITE_N |-> lanes == 4'hf)  // RL4
        else $error("global write missed a lane");
    a_strobe_lanes: assert property (acc_write && ALL_LANE_WRITE_N |->  // RL3
        lanes == ~LANE_WRITE_N)
        else $error("lane mask differs from selects");
    a_desel_decode: assert property (!sleep && !CTRL_ADDR_LOAD_N && !selected |=>  // RL5
        state_reg == SBS_IDLE && !rd1_valid_reg)
        else $error("unselected load started access");
    a_load_start: assert property (load |=> cur_low == $past(ADDR[1:0]) &&  // RL1
        state_reg == SBS_BURST)
        else $error("burst not preset from address");
    a_linear_step: assert property (step && !interleave && $stable(mode_reg) |=>  // RL9
        cur_low == 2'($past(cur_low) + 2'h1))
        else $error("linear step wrong");
    a_interleave_walk: assert property (interleave |-> cur_low == (start_low ^ offset))  // RL9
        else $error("interleaved order wrong");
    a_hold_suspend: assert property (state_reg == SBS_BURST && BURST_STEP_N && !load |=>  // RL7
        $stable(offset))
        else $error("counter moved without advance");
    a_wrap_fifth: assert property (load ##1 (step && !load)[*4] |=>  // RL10
        cur_low == start_low && offset == 2'h0)
        else $error("no wrap on fifth clock");
    // a read after an idle cycle must not show up one cycle early
    a_pipe_latency: assert property (go && !acc_write && pipelined && !$past(go) |=>  // RL22
        DATA_OE_N ##1 rd2_valid_reg)
        else $error("pipelined latency wrong");
    a_single_off: assert property (desel && pipelined && single_desel |=> DATA_OE_N)  // RL19
        else $error("single-cycle deselect late");
    a_dual_off: assert property (desel && pipelined && !single_desel &&  // RL20
        $stable(mode_reg) |=> ##1 DATA_OE_N)
        else $error("dual-cycle deselect late");
    a_mode_defaults: assert property ($past(SRST) |-> mode_reg == SBS_MODE_RST)  // RL16
        else $error("mode not at defaults");

    c_full_burst: cover property (load ##1 step[*3]);
    c_single_desel: cover property (rd2_valid_reg && single_desel && desel1_reg);
    c_global_write: cover property (acc_write && !ALL_LANE_WRITE_N);
    c_flow_read: cover property (!pipelined && drive);

endmodule : sbs_sram_core

// ### verif/sbs_ctrl_model.sv
module sbs_ctrl_model
    import sbs_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // clock from the bench
    input wire logic clk,
    // address and control
    output logic [ADDR_W-1:0] addr,
    output logic cs_low_n,
    output logic cs_high,
    output logic cpu_load_n,
    output logic ctrl_load_n,
    output logic step_n,
    output logic all_wr_n,
    output logic strobe_n,
    output logic [3:0] lanes_n,
    output logic oe_n,
    // write data
    output logic [31:0] data,
    output logic [3:0] parity
);
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================================
    // controller side of the sram pins
    // =====================================================================
    // idle levels: selected, no strobes, no writes, outputs allowed
    initial begin
        {oe_n, cs_low_n, cs_high, cpu_load_n, ctrl_load_n, step_n} = 6'h0f;
        {all_wr_n, strobe_n, lanes_n} = 6'h3f;
        addr = '0;
        data = 32'h0;
        parity = 4'h0;
    end

    // one command per cycle, changed just after the rising edge
    task automatic cmd(input logic [7:0] ctl, input logic [3:0] ln,
                       input logic [ADDR_W-1:0] a, input logic [35:0] d);
        @(posedge clk);
        {oe_n, cs_low_n, cs_high, cpu_load_n, ctrl_load_n} <= ctl[7:3];
        step_n <= ctl[2];
        {all_wr_n, strobe_n, lanes_n} <= {ctl[1:0], ln};
        addr <= a;
        // data lines not written carry the inverse of the last value
        data <= (ctl[1:0] != 2'h3) ? d[31:0] : ~data;
        parity <= (ctl[1:0] != 2'h3) ? d[35:32] : ~parity;
    endtask : cmd
endmodule : sbs_ctrl_model

// ### verif/test_sync_burst_sram_control_and_modes.sv
module test_sync_burst_sram_control_and_modes
    import sbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AW = 6;

    // =====================================================================
    // pins and bench state
    // =====================================================================
    logic REF_CLK = 1'h0;
    logic SRST = 1'h1;
    logic [SBS_AXI_AW-1:0] AWADDR = 4'h0, ARADDR = 4'h0;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'hf;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, DATA_OE_N, PARITY_OE_N;
    logic DRIVE_HIGH, SLEEP_ACTIVE, CHIP_SELECT_LOW_N, CHIP_SELECT_HIGH, CPU_ADDR_LOAD_N;
    logic CTRL_ADDR_LOAD_N, BURST_STEP_N, ALL_LANE_WRITE_N, LANE_WRITE_STROBE_N;
    logic OUTPUT_ENABLE_N;
    logic [1:0] BRESP, RRESP;
    logic [31:0] RDATA, DATA_OUT, DATA_IN;
    logic [3:0] PARITY_OUT, PARITY_IN, LANE_WRITE_N;
    logic [AW-1:0] ADDR;
    logic [31:0] md [4];
    logic [3:0] mp [4];
    int q [$];
    int n_errors = 0, n_checks = 0;

    // 20 mhz clock
    always #25 REF_CLK = ~REF_CLK;

    sbs_sram_core #(.ADDR_W(AW)) uut (
        .REF_CLK, .SRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
        .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
        .RREADY, .ADDR, .CHIP_SELECT_LOW_N, .CHIP_SELECT_HIGH, .CPU_ADDR_LOAD_N,
        .CTRL_ADDR_LOAD_N, .BURST_STEP_N, .ALL_LANE_WRITE_N, .LANE_WRITE_STROBE_N,
        .LANE_WRITE_N, .OUTPUT_ENABLE_N, .DATA_IN, .PARITY_IN, .DATA_OUT, .PARITY_OUT,
        .DATA_OE_N, .PARITY_OE_N, .DRIVE_HIGH, .SLEEP_ACTIVE
    );

    sbs_ctrl_model #(.ADDR_W(AW)) m (
        .clk(REF_CLK), .addr(ADDR), .cs_low_n(CHIP_SELECT_LOW_N), .cs_high(CHIP_SELECT_HIGH),
        .cpu_load_n(CPU_ADDR_LOAD_N), .ctrl_load_n(CTRL_ADDR_LOAD_N), .step_n(BURST_STEP_N),
        .all_wr_n(ALL_LANE_WRITE_N), .strobe_n(LANE_WRITE_STROBE_N), .lanes_n(LANE_WRITE_N),
        .oe_n(OUTPUT_ENABLE_N), .data(DATA_IN), .parity(PARITY_IN)
    );

    // =====================================================================
    // checking and bus tasks
    // =====================================================================
    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] want);
        n_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, want, seen);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // ready is sampled mid-cycle, where it equals its value at the next edge
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        int t;
        t = 0;
        @(posedge REF_CLK);
        AWADDR <= a;
        WDATA <= d;
        {AWVALID, WVALID, BREADY} <= 3'h7;
        do begin
            @(negedge REF_CLK);
            aw_ok = AWVALID && AWREADY;
            w_ok = WVALID && WREADY;
            b_ok = BVALID;
            r = BRESP;
            @(posedge REF_CLK);
            if (aw_ok) AWVALID <= 1'h0;
            if (w_ok) WVALID <= 1'h0;
            t++;
        end while (!b_ok && t < 100);
        BREADY <= 1'h0;
        if (!b_ok) n_errors++;
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok, r_ok;
        int t;
        t = 0;
        @(posedge REF_CLK);
        ARADDR <= a;
        {ARVALID, RREADY} <= 2'h3;
        do begin
            @(negedge REF_CLK);
            ar_ok = ARVALID && ARREADY;
            r_ok = RVALID;
            d = RDATA;
            r = RRESP;
            @(posedge REF_CLK);
            if (ar_ok) ARVALID <= 1'h0;
            t++;
        end while (!r_ok && t < 100);
        RREADY <= 1'h0;
        if (!r_ok) n_errors++;
    endtask : axi_rd

    // write the mode register and confirm readback and mode outputs
    task automatic set_mode(input logic [5:0] mv);
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(SBS_OFF_MODE, {26'h0, mv}, r);
        chk("bresp", r, SBS_RESP_OKAY);
        axi_rd(SBS_OFF_MODE, d, r);
        chk("mode", d, {26'h0, mv});
        chk("drive_high", DRIVE_HIGH, !mv[3]);
        chk("sleep_active", SLEEP_ACTIVE, mv[5]);
    endtask : set_mode

    // =====================================================================
    // main sequence
    // =====================================================================
    initial begin
        logic [31:0] d;
        logic [35:0] wd;
        logic [1:0] r;
        logic [3:0] ln;
        logic [5:0] mv;
        logic [7:0] ctl;
        int s, off, k, w;
        bit on;
        void'($urandom(32'h2ca1));
        repeat (16) @(posedge REF_CLK);
        SRST <= 1'h0;
        // reset values and refused accesses
        axi_rd(SBS_OFF_MODE, d, r);
        chk("mode_rst", d, {26'h0, SBS_MODE_RST});
        chk("drive_rst", DRIVE_HIGH, 1'h0);
        axi_rd(SBS_OFF_STATUS, d, r);
        chk("status_rst", d[4:2], 3'h0);
        axi_rd(4'h8, d, r);
        chk("rd_unmapped", {r, d}, {SBS_RESP_SLVERR, 32'h0});
        axi_wr(SBS_OFF_STATUS, 32'h3f, r);
        chk("bresp_ro", r, SBS_RESP_SLVERR);
        // full-word writes, then lane-selective writes with random lanes
        for (int i = 0; i < 12; i++) begin
            w = i % 4;
            ln = 4'($urandom);
            wd = {4'($urandom), $urandom};
            m.cmd(i < 4 ? 8'h35 : 8'h36, ln, {4'h5, 2'(w)}, wd);
            for (int l = 0; l < 4; l++) begin
                if (i < 4 || !ln[l]) begin
                    md[w][8*l+:8] = wd[8*l+:8];
                    mp[w][l] = wd[32+l];
                end
            end
        end
        // a write with the chip deselected leaves word 0 alone
        m.cmd(8'h15, 4'h0, {4'h5, 2'h0}, ~{mp[0], md[0]});
        // standby refuses commands and keeps contents
        set_mode(6'h2f);
        m.cmd(8'h35, 4'h0, {4'h5, 2'h1}, ~{mp[1], md[1]});
        m.cmd(8'h37, 4'hf, {4'h5, 2'h1}, 36'h0);
        repeat (2) begin
            m.cmd(8'h3f, 4'hf, {4'h5, 2'h1}, 36'h0);
            @(negedge REF_CLK);
            chk("oe_sleep", DATA_OE_N, 1'h1);
        end
        // every order, output and deselect mode, one burst of reads each
        for (int j = 0; j < 8; j++) begin
            mv = {1'h0, j == 7, j != 2, 3'(j)};
            set_mode(mv);
            s = $urandom % 4;
            off = 0;
            q.delete();
            for (int i = 0; i <= 9; i++) begin
                ctl = i == 0 ? (j % 2 ? 8'h2f : 8'h37) : i == 7 ? (j & 2 ? 8'h77 : 8'h17)
                    : ((i == 3 && j < 4) || i > 7) ? 8'h3f : 8'h3b;
                ctl[7] = i == 4 && j == 3;
                // single-deselect modes step six times in a row to pass the wrap
                if (i > 0 && i < 7 && (i != 3 || j > 3)) off++;
                if (i < 7) q.push_back(mv[0] ? s ^ (off % 4) : (s + off) % 4);
                m.cmd(ctl, 4'hf, {4'h5, 2'(s)}, 36'h0);
                @(negedge REF_CLK);
                k = i - 1 - mv[1];
                on = k >= 0 && k <= 6 && !ctl[7] && (!mv[1] || i < (mv[2] ? 8 : 9));
                chk("data_oe_n", DATA_OE_N, !on);
                chk("parity_oe_n", PARITY_OE_N, !on || mv[4]);
                if (on) begin
                    chk("data_out", DATA_OUT, md[q[k]]);
                    chk("parity_out", PARITY_OUT, mv[4] ? 4'h0 : mp[q[k]]);
                end
            end
        end
        wrap_up();
    end

    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #(2000 * 50);
        n_errors++;
        wrap_up();
    end
endmodule : test_sync_burst_sram_control_and_modes
